// File: pkg/fsl_regs.svh
// Register offsets, field positions, reset values and timing counts of the start limiter
`ifndef FSL_REGS_SVH
`define FSL_REGS_SVH

`define FSL_ADDR_CTRL 8'h00
`define FSL_ADDR_STARTS 8'h04
`define FSL_ADDR_STALL 8'h08
`define FSL_ADDR_TIMING 8'h0C
`define FSL_ADDR_STATUS 8'h10
`define FSL_ADDR_CNT_LO 8'h14
`define FSL_ADDR_CNT_HI 8'h18
`define FSL_ADDR_INH_TIME 8'h1C
`define FSL_ADDR_ALM_TIME 8'h20
`define FSL_ADDR_SINCE 8'h24

`define FSL_CTRL_EN_BIT 0
`define FSL_STARTS_COLD_LSB 0
`define FSL_STARTS_HOT_LSB 8
`define FSL_STARTS_HOURS_LSB 16
`define FSL_STALL_HOT_LSB 0
`define FSL_STALL_COLD_LSB 16
`define FSL_TIMING_MIN_LSB 0
`define FSL_TIMING_LIMIT_LSB 16
`define FSL_STATUS_HOT_BIT 2
`define FSL_STATUS_ALM_BIT 3
`define FSL_STATUS_INH_BIT 4
`define FSL_STATUS_BLK_BIT 5
`define FSL_STATUS_USED_LSB 8
`define FSL_STATUS_AVAIL_LSB 16

`define FSL_RST_EN 1'h1
`define FSL_RST_STARTS_COLD 7'h03
`define FSL_RST_STARTS_HOT 7'h02
`define FSL_RST_HOURS 7'h01
`define FSL_RST_STALL_HOT 13'h0096
`define FSL_RST_STALL_COLD 13'h00C8
`define FSL_RST_MIN_TIME 13'h00C8
`define FSL_RST_THETA_LIMIT 10'h2BC

`define FSL_CLK_PERIOD_NS 50
`define FSL_PROG_CYCLE_US 5000
`define FSL_PROG_CYCLE_CLKS (`FSL_PROG_CYCLE_US * 1000 / `FSL_CLK_PERIOD_NS)
`define FSL_DS_US 100000
`define FSL_PCYC_PER_DS (`FSL_DS_US / `FSL_PROG_CYCLE_US)
`define FSL_HOUR_MS 3600000
`define FSL_PCYC_PER_HOUR (`FSL_HOUR_MS / (`FSL_PROG_CYCLE_US / 1000))

`endif

// File: pkg/fsl_pkg.sv
// Types shared by the start limiter modules
package fsl_pkg;
	typedef enum logic [1:0] {FSL_COND_NORMAL, FSL_COND_START, FSL_COND_TRIP, FSL_COND_BLOCKED}
		fsl_cond_type;
	typedef enum logic [2:0] {FSL_EVT_ALM_ON, FSL_EVT_ALM_OFF, FSL_EVT_INH_ON, FSL_EVT_INH_OFF,
		FSL_EVT_BLK_ON, FSL_EVT_BLK_OFF} fsl_evt_type;
	typedef enum logic {FSL_Q_IDLE, FSL_Q_RUN} fsl_qstate_type;
endpackage : fsl_pkg

// File: rtl/fsl_div.sv
// Program cycle enable divider
`timescale 1ns/1ns
module fsl_div #(
	parameter int COUNT = 100000
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	output logic tick
);
	logic [31:0] cnt_q;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q <= 32'h0000_0000;
			tick <= 1'b0;
		end
		else if (cnt_q == 32'(COUNT - 1))
		begin
			cnt_q <= 32'h0000_0000;
			tick <= 1'b1;
		end
		else
		begin
			cnt_q <= cnt_q + 32'h0000_0001;
			tick <= 1'b0;
		end
	end
endmodule : fsl_div

// File: rtl/fsl_quot.sv
// Repeated-subtraction divider giving the rounded-up number of starts held in the counter
`timescale 1ns/1ns
module fsl_quot
	import fsl_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic go,
	input wire logic [47:0] dividend,
	input wire logic [39:0] divisor,
	output logic [7:0] quot,
	output logic done
);
	fsl_qstate_type state_q;
	logic [47:0] rem_q;
	logic [39:0] div_q;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= FSL_Q_IDLE;
			rem_q <= 48'h0;
			div_q <= 40'h0;
			quot <= 8'h00;
			done <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			case (state_q)
				FSL_Q_IDLE:
					if (go)
					begin
						rem_q <= dividend;
						div_q <= divisor;
						quot <= 8'h00;
						state_q <= FSL_Q_RUN;
					end
				FSL_Q_RUN:
					// Bounded at 255 passes so the 8-bit quotient cannot wrap; a zero divisor ends the loop at once
					if (rem_q == 48'h0 || quot == 8'hFF || div_q == 40'h0)
					begin
						done <= 1'b1;
						state_q <= FSL_Q_IDLE;
					end
					else
					begin
						rem_q <= (rem_q > {8'h00, div_q}) ? rem_q - {8'h00, div_q} : 48'h0;
						quot <= quot + 8'h01;
					end
				default:
					state_q <= FSL_Q_IDLE;
			endcase
		end
	end
endmodule : fsl_quot

// File: rtl/fsl_top.sv
// Frequent start limiter: starts counter, alarm, restart inhibit and register port
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
`include "fsl_regs.svh"

module fsl_top
	import fsl_pkg::*;
#(
	parameter int PROG_CYCLE_CLKS = `FSL_PROG_CYCLE_CLKS
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic motor_current_high,
	input wire logic block_pin,
	input wire logic [9:0] theta_used,
	input wire logic theta_valid,
	output logic alarm_on,
	output logic inhibit_on,
	output logic blocked_on,
	output logic hot_state,
	output fsl_cond_type condition,
	output logic evt_valid,
	output fsl_evt_type evt_code,
	output logic [31:0] evt_stamp,
	output logic [9:0] shared_theta_limit,
	output logic [12:0] shared_stall_hot,
	output logic [12:0] shared_stall_cold,
	output logic [7:0] starts_used,
	output logic [7:0] starts_avail
);
	logic en_q;
	logic [6:0] starts_cold_q;
	logic [6:0] starts_hot_q;
	logic [6:0] hours_q;
	logic [12:0] min_time_q;
	logic [1:0] cur_sync_q;
	logic [1:0] blk_sync_q;
	logic cur_prev_q;
	logic tick;
	logic start_det;
	logic start_acc;
	logic [12:0] stall_eff;
	logic [6:0] allowed;
	logic [26:0] win_cycles;
	logic [39:0] unit_amt;
	logic [19:0] dec_amt;
	logic [47:0] cnt_q;
	logic [47:0] cnt_sum;
	logic [31:0] since_q;
	logic [31:0] min_cycles;
	logic too_soon;
	logic [7:0] quot;
	logic quot_done;
	logic [31:0] inh_time_q;
	logic [31:0] alm_time_q;
	logic [31:0] stamp_q;
	logic [5:0] pend_q;
	logic [5:0] pend_set;
	logic [5:0] pend_clr;

	fsl_div #(
		.COUNT(PROG_CYCLE_CLKS)
	) u_div (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.tick(tick)
	);

	// Settings registers; the outputs are the single copy other functions read
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			en_q <= `FSL_RST_EN;
			starts_cold_q <= `FSL_RST_STARTS_COLD;
			starts_hot_q <= `FSL_RST_STARTS_HOT;
			hours_q <= `FSL_RST_HOURS;
			shared_stall_hot <= `FSL_RST_STALL_HOT;
			shared_stall_cold <= `FSL_RST_STALL_COLD;
			min_time_q <= `FSL_RST_MIN_TIME;
			shared_theta_limit <= `FSL_RST_THETA_LIMIT;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				`FSL_ADDR_CTRL:
					en_q <= reg_wdata[`FSL_CTRL_EN_BIT];
				`FSL_ADDR_STARTS:
				begin
					starts_cold_q <= reg_wdata[`FSL_STARTS_COLD_LSB +: 7];
					starts_hot_q <= reg_wdata[`FSL_STARTS_HOT_LSB +: 7];
					hours_q <= reg_wdata[`FSL_STARTS_HOURS_LSB +: 7];
				end
				`FSL_ADDR_STALL:
				begin
					shared_stall_hot <= reg_wdata[`FSL_STALL_HOT_LSB +: 13];
					shared_stall_cold <= reg_wdata[`FSL_STALL_COLD_LSB +: 13];
				end
				`FSL_ADDR_TIMING:
				begin
					min_time_q <= reg_wdata[`FSL_TIMING_MIN_LSB +: 13];
					shared_theta_limit <= reg_wdata[`FSL_TIMING_LIMIT_LSB +: 10];
				end
				default:
					en_q <= en_q;
			endcase
		end
	end

	// Pins pass two flops before use
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cur_sync_q <= 2'h0;
			blk_sync_q <= 2'h0;
			cur_prev_q <= 1'b0;
		end
		else
		begin
			cur_sync_q <= {cur_sync_q[0], motor_current_high};
			blk_sync_q <= {blk_sync_q[0], block_pin};
			cur_prev_q <= cur_sync_q[1];
		end
	end

	// Rising motor current marks a start or start attempt
	assign start_det = cur_sync_q[1] && !cur_prev_q;
	assign start_acc = start_det && en_q && !blocked_on;

	// Thermal state only counts as hot when the overload function is supplying data
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			hot_state <= 1'b0;
		else
			hot_state <= theta_valid && (theta_used > shared_theta_limit);
	end

	assign stall_eff = hot_state ? shared_stall_hot :
		(shared_stall_cold == 13'h0000) ? shared_stall_hot : shared_stall_cold;
	assign allowed = hot_state ? starts_hot_q : starts_cold_q;
	assign win_cycles = 27'(hours_q * 27'(`FSL_PCYC_PER_HOUR));
	// One start weighs stall * window; the window drains allowed * stall per cycle
	assign unit_amt = 40'(stall_eff) * 40'(win_cycles);
	assign dec_amt = 20'(allowed) * 20'(stall_eff);
	assign cnt_sum = cnt_q + (start_acc ? {8'h00, unit_amt} : 48'h0);

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_q <= 48'h0;
		else if (!tick)
			cnt_q <= cnt_sum;
		else if (cnt_sum > {28'h0, dec_amt})
			cnt_q <= cnt_sum - {28'h0, dec_amt};
		else
			cnt_q <= 48'h0;
	end

	// Time since last start, in program cycles, saturating
	assign min_cycles = 32'(min_time_q * 32'(`FSL_PCYC_PER_DS));
	assign too_soon = since_q < min_cycles;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			since_q <= 32'hFFFF_FFFF;
		else if (start_acc)
			since_q <= 32'h0000_0000;
		else if (tick && since_q != 32'hFFFF_FFFF)
			since_q <= since_q + 32'h0000_0001;
	end

	fsl_quot u_quot (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.go(1'b1),
		.dividend(cnt_q),
		.divisor(unit_amt),
		.quot(quot),
		.done(quot_done)
	);

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			starts_used <= 8'h00;
			starts_avail <= 8'h00;
		end
		else if (quot_done)
		begin
			starts_used <= quot;
			starts_avail <= (quot >= {1'b0, allowed}) ? 8'h00 : {1'b0, allowed} - quot;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			alarm_on <= 1'b0;
			inhibit_on <= 1'b0;
			blocked_on <= 1'b0;
		end
		else
		begin
			blocked_on <= en_q && blk_sync_q[1];
			alarm_on <= en_q && !blk_sync_q[1] && starts_avail == 8'h01;
			inhibit_on <= en_q && !blk_sync_q[1] && (starts_avail == 8'h00 || too_soon);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			condition <= FSL_COND_NORMAL;
		else if (blocked_on)
			condition <= FSL_COND_BLOCKED;
		else if (inhibit_on)
			condition <= FSL_COND_TRIP;
		else if (alarm_on)
			condition <= FSL_COND_START;
		else
			condition <= FSL_COND_NORMAL;
	end

	// Active durations in program cycles, restarted on each rise
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			inh_time_q <= 32'h0000_0000;
			alm_time_q <= 32'h0000_0000;
			stamp_q <= 32'h0000_0000;
		end
		else
		begin
			if (!inhibit_on)
				inh_time_q <= 32'h0000_0000;
			else if (tick)
				inh_time_q <= inh_time_q + 32'h0000_0001;
			if (!alarm_on)
				alm_time_q <= 32'h0000_0000;
			else if (tick)
				alm_time_q <= alm_time_q + 32'h0000_0001;
			if (tick)
				stamp_q <= stamp_q + 32'h0000_0001;
		end
	end

	// Changes queue as pending bits so simultaneous ones all come out
	assign pend_set = {blocked_on && !blk_sync_q[1] || !en_q && blocked_on,
		!blocked_on && en_q && blk_sync_q[1],
		inhibit_on && !(en_q && !blk_sync_q[1] && (starts_avail == 8'h00 || too_soon)),
		!inhibit_on && en_q && !blk_sync_q[1] && (starts_avail == 8'h00 || too_soon),
		alarm_on && !(en_q && !blk_sync_q[1] && starts_avail == 8'h01),
		!alarm_on && en_q && !blk_sync_q[1] && starts_avail == 8'h01};
	assign pend_clr = pend_q & (~pend_q + 6'h01);

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pend_q <= 6'h00;
			evt_valid <= 1'b0;
			evt_code <= FSL_EVT_ALM_ON;
			evt_stamp <= 32'h0000_0000;
		end
		else
		begin
			pend_q <= (pend_q & ~pend_clr) | pend_set;
			evt_valid <= pend_q != 6'h00;
			evt_stamp <= stamp_q;
			case (pend_clr)
				6'h01: evt_code <= FSL_EVT_ALM_ON;
				6'h02: evt_code <= FSL_EVT_ALM_OFF;
				6'h04: evt_code <= FSL_EVT_INH_ON;
				6'h08: evt_code <= FSL_EVT_INH_OFF;
				6'h10: evt_code <= FSL_EVT_BLK_ON;
				6'h20: evt_code <= FSL_EVT_BLK_OFF;
				default: evt_code <= evt_code;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= 32'h0000_0000;
		else if (!reg_rd)
			reg_rdata <= 32'h0000_0000;
		else
		begin
			case (reg_addr)
				`FSL_ADDR_CTRL: reg_rdata <= {31'h0, en_q};
				`FSL_ADDR_STARTS: reg_rdata <= {9'h0, hours_q, 1'b0, starts_hot_q, 1'b0, starts_cold_q};
				`FSL_ADDR_STALL: reg_rdata <= {3'h0, shared_stall_cold, 3'h0, shared_stall_hot};
				`FSL_ADDR_TIMING: reg_rdata <= {6'h0, shared_theta_limit, 3'h0, min_time_q};
				`FSL_ADDR_STATUS: reg_rdata <= {8'h0, starts_avail, starts_used, 2'h0, blocked_on,
					inhibit_on, alarm_on, hot_state, condition};
				`FSL_ADDR_CNT_LO: reg_rdata <= cnt_q[31:0];
				`FSL_ADDR_CNT_HI: reg_rdata <= {16'h0, cnt_q[47:32]};
				`FSL_ADDR_INH_TIME: reg_rdata <= inh_time_q;
				`FSL_ADDR_ALM_TIME: reg_rdata <= alm_time_q;
				`FSL_ADDR_SINCE: reg_rdata <= since_q;
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end
	end

	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	property p_start_add;
		start_acc && !tick |=> cnt_q == $past(cnt_q) + {8'h00, $past(unit_amt)};
	endproperty
	a_start_add: assert property (p_start_add) else $error("start did not add stall weight");

	property p_decay;
		tick && !start_acc && cnt_q > {28'h0, dec_amt} |=> cnt_q == $past(cnt_q) - {28'h0, $past(dec_amt)};
	endproperty
	a_decay: assert property (p_decay) else $error("counter decay wrong");

	property p_floor;
		tick && !start_acc && cnt_q <= {28'h0, dec_amt} |=> cnt_q == 48'h0;
	endproperty
	a_floor: assert property (p_floor) else $error("counter not held at zero");

	property p_alarm;
		en_q && !blk_sync_q[1] && starts_avail == 8'h01 |=> alarm_on
			##1 condition == ($past(inhibit_on) ? FSL_COND_TRIP : FSL_COND_START);
	endproperty
	a_alarm: assert property (p_alarm) else $error("alarm missing with one start left");

	property p_inhibit;
		en_q && !blk_sync_q[1] && starts_avail == 8'h00 |=> inhibit_on ##1 condition == FSL_COND_TRIP;
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("inhibit missing with no start left");

	property p_too_soon;
		start_acc && min_time_q != 13'h0000 && en_q && !blk_sync_q[1] |=> ##1 inhibit_on;
	endproperty
	a_too_soon: assert property (p_too_soon) else $error("early start not inhibited");

	property p_hot;
		theta_valid && theta_used > shared_theta_limit |=> hot_state && allowed == starts_hot_q;
	endproperty
	a_hot: assert property (p_hot) else $error("hot state or hot rate not taken");

	property p_cold_default;
		!hot_state && shared_stall_cold == 13'h0000 |-> stall_eff == shared_stall_hot;
	endproperty
	a_cold_default: assert property (p_cold_default) else $error("cold stall default wrong");

	property p_blocked;
		blocked_on |-> !alarm_on && !inhibit_on ##1 condition == FSL_COND_BLOCKED;
	endproperty
	a_blocked: assert property (p_blocked) else $error("blocked state not exclusive");
endmodule : fsl_top

// File: test/fsl_motor_model.sv
// Model of the motor current pin and the thermal overload data feed
`timescale 1ns/1ns
module fsl_motor_model #(
	parameter int RUN_CLKS = 12
) (
	input wire logic sys_clk,
	input wire logic start_cmd,
	input wire logic [9:0] theta_set,
	input wire logic theta_on,
	output logic motor_current_high,
	output logic [9:0] theta_used,
	output logic theta_valid
);
	int run_cnt = 0;
	// Current falls after a short run so that the next start shows as a new rising edge
	always @(posedge sys_clk)
	begin
		if (start_cmd)
			run_cnt <= RUN_CLKS;
		else if (run_cnt > 0)
			run_cnt <= run_cnt - 1;
		motor_current_high <= start_cmd || run_cnt > 1;
	end
	// Stale data is scrambled, not held, while the thermal function is off
	always @(posedge sys_clk)
	begin
		theta_valid <= theta_on;
		theta_used <= theta_on ? theta_set : ~theta_used;
	end
endmodule : fsl_motor_model

// File: test/fsl_top_tb.sv
// Self-checking bench of the frequent start limiter
`timescale 1ns/1ns
module fsl_top_tb
	import fsl_pkg::*;
;
	typedef struct {
		logic [7:0] addr;
		logic [9:0] theta;
		logic valid;
		logic [31:0] rdata;
		logic hot;
	} fsl_row_type;
	fsl_row_type rows[7] = '{
		'{8'h00, 10'h000, 1'b1, 32'h0000_0001, 1'b0},
		'{8'h04, 10'h2BC, 1'b1, 32'h0001_0203, 1'b0},
		'{8'h08, 10'h2BD, 1'b1, 32'h00C8_0096, 1'b1},
		'{8'h0C, 10'h3E8, 1'b0, 32'h02BC_00C8, 1'b0},
		'{8'h14, 10'h000, 1'b1, 32'h0000_0000, 1'b0},
		'{8'h30, 10'h000, 1'b1, 32'h0000_0000, 1'b0},
		'{8'h10, 10'h000, 1'b1, 32'h0003_0000, 1'b0}};
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic block_pin = 1'b0;
	logic start_cmd = 1'b0;
	logic theta_on = 1'b1;
	logic [9:0] theta_set = 10'h000;
	logic [31:0] reg_rdata, rd_val, c0, evt_stamp;
	logic motor_current_high, theta_valid, alarm_on, inhibit_on, blocked_on, hot_state, evt_valid;
	logic [9:0] theta_used, sh_lim;
	logic [12:0] sh_hot, sh_cold;
	logic [7:0] starts_used, starts_avail;
	fsl_cond_type condition;
	fsl_evt_type evt_code;
	int errors = 0;
	int n_checks = 0;
	int cycles = 0;

	always #25 sys_clk = ~sys_clk;

	fsl_motor_model u_motor (.sys_clk(sys_clk), .start_cmd(start_cmd), .theta_set(theta_set),
		.theta_on(theta_on), .motor_current_high(motor_current_high), .theta_used(theta_used),
		.theta_valid(theta_valid));

	// Short program cycle keeps the min-time and decay windows to a few hundred clocks
	fsl_top #(.PROG_CYCLE_CLKS(20)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .motor_current_high(motor_current_high), .block_pin(block_pin),
		.theta_used(theta_used), .theta_valid(theta_valid), .alarm_on(alarm_on),
		.inhibit_on(inhibit_on), .blocked_on(blocked_on), .hot_state(hot_state),
		.condition(condition), .evt_valid(evt_valid), .evt_code(evt_code), .evt_stamp(evt_stamp),
		.shared_theta_limit(sh_lim), .shared_stall_hot(sh_hot), .shared_stall_cold(sh_cold),
		.starts_used(starts_used), .starts_avail(starts_avail));

	task automatic report_and_stop();
		if (errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [7:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask : reg_read

	task automatic motor_start();
		@(posedge sys_clk);
		start_cmd <= 1'b1;
		@(posedge sys_clk);
		start_cmd <= 1'b0;
	endtask : motor_start

	task automatic wait_evt(input fsl_evt_type code);
		int n;
		n = 0;
		while (!(evt_valid === 1'b1 && evt_code === code) && n < 300)
		begin
			@(posedge sys_clk);
			#1 n++;
		end
		check(n < 300, 32'h0000_0001);
	endtask : wait_evt

	// Counter reads exactly 200 clocks apart, i.e. ten program cycles
	task automatic decay_window(input logic do_start);
		reg_read(8'h14);
		c0 = rd_val;
		@(posedge sys_clk);
		start_cmd <= do_start;
		@(posedge sys_clk);
		start_cmd <= 1'b0;
		cyc(196);
		reg_read(8'h14);
	endtask : decay_window

	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 10000)
		begin
			errors++;
			report_and_stop();
		end
	end

	initial
	begin
		cyc(4);
		rst_n <= 1'b1;
		cyc(10);
		foreach (rows[i])
		begin
			theta_set <= rows[i].theta;
			theta_on <= rows[i].valid;
			cyc(120);
			reg_read(rows[i].addr);
			check(rd_val, rows[i].rdata);
			check(hot_state, rows[i].hot);
		end
		theta_on <= 1'b1;
		reg_write(8'h0C, 32'h02BC_0001);
		motor_start();
		wait_evt(FSL_EVT_INH_ON);
		check(condition, FSL_COND_TRIP);
		cyc(500);
		check({inhibit_on, alarm_on, starts_used, starts_avail}, {2'b00, 8'h01, 8'h02});
		motor_start();
		wait_evt(FSL_EVT_ALM_ON);
		cyc(500);
		check({alarm_on, condition, starts_avail}, {1'b1, FSL_COND_START, 8'h01});
		motor_start();
		cyc(500);
		check({inhibit_on, alarm_on, condition, starts_avail}, {2'b10, FSL_COND_TRIP, 8'h00});
		for (int h = 0; h < 2; h++)
		begin
			theta_set <= (h == 1) ? 10'h320 : 10'h000;
			cyc(120);
			decay_window(1'b0);
			check(c0 - rd_val, (h == 1) ? 32'h0000_0BB8 : 32'h0000_1770);
		end
		theta_set <= 10'h000;
		block_pin <= 1'b1;
		wait_evt(FSL_EVT_BLK_ON);
		cyc(4);
		check({blocked_on, inhibit_on, alarm_on, condition}, {3'b100, FSL_COND_BLOCKED});
		decay_window(1'b1);
		check(c0 - rd_val, 32'h0000_1770);
		block_pin <= 1'b0;
		reg_write(8'h08, 32'h0000_0096);
		cyc(4);
		check({sh_hot, sh_cold}, {13'h0096, 13'h0000});
		// Unspecified cold stall falls back to the hot one for add and decay
		decay_window(1'b1);
		check(rd_val - c0, 32'h066F_E16C);
		rst_n <= 1'b0;
		cyc(2);
		check(sh_lim, 10'h2BC);
		check({sh_hot, sh_cold}, {13'h0096, 13'h00C8});
		check({alarm_on, inhibit_on, blocked_on, evt_valid}, 32'h0000_0000);
		rst_n <= 1'b1;
		// Avail reads zero until the first quotient, so a short inhibit pulse follows reset
		wait_evt(FSL_EVT_INH_ON);
		check(evt_stamp, 32'h0000_0000);
		wait_evt(FSL_EVT_INH_OFF);
		cyc(10);
		reg_read(8'h14);
		check(rd_val, 32'h0000_0000);
		// Disabled: no blocked state and no start taken into the counter
		reg_write(8'h00, 32'h0000_0000);
		block_pin <= 1'b1;
		motor_start();
		cyc(20);
		check({blocked_on, inhibit_on, alarm_on, condition}, {3'b000, FSL_COND_NORMAL});
		reg_read(8'h14);
		check(rd_val, 32'h0000_0000);
		report_and_stop();
	end
endmodule : fsl_top_tb
